// File: rtl/alc_input_volume_deemphasis.sv
// level-control config, manual input volume and de-emphasis data path
`include "alc_vol_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module alc_input_volume_deemphasis
  import alc_vol_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // incoming samples, one per sample period
  input wire logic in_valid,
  input wire logic [23:0] in_left,
  input wire logic [23:0] in_right,
  output logic in_ready,
  // processed samples
  output logic out_valid,
  output logic [23:0] out_left,
  output logic [23:0] out_right,
  input wire logic out_ready
);

  // control registers
  logic [7:0] ctrl;
  logic [7:0] zc_cfg;
  logic [7:0] lim_cfg;
  logic [7:0] rec_recovery_ceiling;
  logic [5:0] play_recovery_ceiling;
  logic [7:0] in_vol_left;
  logic [7:0] in_vol_right;

  // datapath state
  logic s1_valid;
  sample_t out_data [2];
  logic [7:0] applied [2];
  logic [7:0] last_tgt [2];
  logic pending [2];
  logic [10:0] zc_count [2];
  logic prev_sign [2];

  // software hazard flags
  logic retune_seen;
  logic rewrite_seen;

  // fifo drain side
  logic fifo_valid;
  logic [47:0] fifo_data;

  // field decode
  wire logic rec_level_ctrl_en = ctrl[`CTRL_REC_EN];
  wire logic play_level_ctrl_en = ctrl[`CTRL_PLAY_EN];
  wire logic adc_filter_path_sel = ctrl[`CTRL_PATH_SEL];
  wire logic filter_block_power = ctrl[`CTRL_POWER];
  wire logic in_vol_link = ctrl[`CTRL_LINK];
  wire deemph_mode_t deemph_select = deemph_mode_t'(ctrl[`CTRL_DEEMPH_LSB +: 2]);
  wire logic [1:0] zc_timeout_sel = zc_cfg[`ZC_SEL_LSB +: 2];
  wire logic limiter_zc_disable = zc_cfg[`ZC_LIM_DIS];
  wire logic [2:0] recovery_wait_sel = zc_cfg[`WAIT_SEL_LSB +: 3];

  wire logic manual_mode = !rec_level_ctrl_en && adc_filter_path_sel;
  wire logic level_zero = !rec_level_ctrl_en && !play_level_ctrl_en && !manual_mode;
  wire vol_mode_t vol_mode = level_zero ? VOL_ZERO : manual_mode ? VOL_MANUAL : VOL_LEVEL_CTRL;

  wire logic [10:0] zc_limit = `ZC_BASE_COUNT << zc_timeout_sel;
  // crossing bypass only under level control
  wire logic use_zc = !rec_level_ctrl_en || !limiter_zc_disable;

  // recovery wait shorter than the timeout
  wire logic wait_short = recovery_wait_sel < {1'b0, zc_timeout_sel};
  // tuning write while level control runs
  wire logic tune_addr = reg_addr == `ADDR_ZC_CFG || reg_addr == `ADDR_LIM_CFG ||
    reg_addr == `ADDR_REC_CEIL || reg_addr == `ADDR_PLAY_CEIL;
  wire logic tune_hazard = reg_wr && tune_addr && (rec_level_ctrl_en || play_level_ctrl_en);
  wire logic status_rd = reg_rd && reg_addr == `ADDR_STATUS;
  // new value while the previous one waits
  wire logic [1:0] early_rewrite;

  // status word, hazard flags in the top bits
  wire logic [7:0] status_word = {rewrite_seen, retune_seen, wait_short, pending[1], pending[0],
    vol_mode == VOL_LEVEL_CTRL, manual_mode, level_zero};

  // one sample in flight; stall the fifo while the output is held
  wire logic stage_free = !s1_valid && (!out_valid || out_ready);
  wire logic pop = fifo_valid && stage_free;

  // right channel follows left when linked
  wire logic [7:0] tgt [2];
  assign tgt[0] = in_vol_left;
  assign tgt[1] = in_vol_link ? in_vol_left : in_vol_right;

  wire sample_t in_sample [2];
  assign in_sample[0] = fifo_data[23:0];
  assign in_sample[1] = fifo_data[47:24];

  wire sample_t filt [2];

  // 2^(f/16) in Q1.15
  function automatic logic [15:0] gain_mant(input logic [3:0] f);
    logic [15:0] m;
    m = 16'h8000;
    unique case (f)
      4'h0: m = 16'h8000;
      4'h1: m = 16'h85AB;
      4'h2: m = 16'h8B96;
      4'h3: m = 16'h91C4;
      4'h4: m = 16'h9838;
      4'h5: m = 16'h9EF5;
      4'h6: m = 16'hA5FF;
      4'h7: m = 16'hAD58;
      4'h8: m = 16'hB505;
      4'h9: m = 16'hBD09;
      4'hA: m = 16'hC567;
      4'hB: m = 16'hCE25;
      4'hC: m = 16'hD745;
      4'hD: m = 16'hE0CD;
      4'hE: m = 16'hEAC1;
      4'hF: m = 16'hF525;
    endcase
    return m;
  endfunction : gain_mant

  function automatic sample_t sat24(input logic signed [40:0] v);
    logic fits;
    fits = v[40:23] == {18{v[23]}};
    return fits ? v[23:0] : {v[40], {23{~v[40]}}};
  endfunction : sat24

  function automatic logic [7:0] read_value(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `ADDR_CTRL: v = ctrl;
      `ADDR_ZC_CFG: v = zc_cfg;
      `ADDR_LIM_CFG: v = lim_cfg;
      `ADDR_REC_CEIL: v = rec_recovery_ceiling;
      `ADDR_PLAY_CEIL: v = {2'h0, play_recovery_ceiling};
      `ADDR_VOL_LEFT: v = in_vol_left;
      `ADDR_VOL_RIGHT: v = in_vol_right;
      `ADDR_APPLIED_LEFT: v = applied[0];
      `ADDR_APPLIED_RIGHT: v = applied[1];
      `ADDR_STATUS: v = status_word;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_value

  sample_fifo #(
    .WIDTH(48),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(in_valid),
    .in_data({in_right, in_left}),
    .in_ready(in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(stage_free)
  );

  // register writes
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ctrl <= `CTRL_RESET;
      zc_cfg <= `ZC_CFG_RESET;
      lim_cfg <= `LIM_CFG_RESET;
      // ceilings reset to +30dB and +6dB
      rec_recovery_ceiling <= `REC_CEIL_RESET;
      play_recovery_ceiling <= `PLAY_CEIL_RESET;
      in_vol_left <= `IN_VOL_RESET;
      in_vol_right <= `IN_VOL_RESET;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `ADDR_CTRL: ctrl <= reg_wdata;
        `ADDR_ZC_CFG: zc_cfg <= reg_wdata;
        `ADDR_LIM_CFG: lim_cfg <= reg_wdata;
        `ADDR_REC_CEIL: rec_recovery_ceiling <= reg_wdata;
        `ADDR_PLAY_CEIL: play_recovery_ceiling <= reg_wdata[5:0];
        `ADDR_VOL_LEFT: in_vol_left <= reg_wdata;
        `ADDR_VOL_RIGHT: in_vol_right <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? read_value(reg_addr) : 8'h00;
  end

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    wire logic zc = pop && (in_sample[ch][23] != prev_sign[ch]);
    wire logic changed = tgt[ch] != last_tgt[ch];
    wire logic tick = pending[ch] && filter_block_power && pop;
    // limit doubles with each step of zc_timeout_sel
    wire logic timeout_hit = zc_count[ch] == zc_limit - 11'h001;
    wire logic apply = tick && (zc || !use_zc || timeout_hit);
    assign early_rewrite[ch] = changed && pending[ch];

    // code to shift and mantissa
    // codes above the top step hold at +36dB
    wire logic [7:0] code = applied[ch] > `VOL_MAX ? `VOL_MAX : applied[ch];
    wire logic signed [8:0] steps = $signed({1'b0, code}) - $signed(`VOL_UNITY);
    wire logic signed [4:0] octave = steps[8:4];
    wire logic [5:0] shift = 6'd15 - 6'(octave);
    wire logic signed [40:0] prod = filt[ch] * $signed({1'b0, gain_mant(steps[3:0])});
    wire logic signed [40:0] scaled = prod >>> shift;
    wire logic silent = applied[ch] == `VOL_MUTE || vol_mode == VOL_ZERO;

    deemph_filter u_deemph (
      .clock(clock),
      .rst_b(rst_b),
      .step(pop),
      .mode(deemph_select),
      .x(in_sample[ch]),
      .y(filt[ch])
    );

    always_ff @(posedge clock)
    begin
      if (!rst_b)
      begin
        applied[ch] <= `IN_VOL_RESET;
        last_tgt[ch] <= `IN_VOL_RESET;
        pending[ch] <= 1'b0;
        zc_count[ch] <= 11'h000;
      end
      else
      begin
        last_tgt[ch] <= tgt[ch];
        // each new value restarts the wait
        if (changed)
        begin
          pending[ch] <= 1'b1;
          zc_count[ch] <= 11'h000;
        end
        else if (apply)
        begin
          applied[ch] <= last_tgt[ch];
          pending[ch] <= 1'b0;
          zc_count[ch] <= 11'h000;
        end
        else if (tick)
          zc_count[ch] <= zc_count[ch] + 11'h001;
      end
    end

    always_ff @(posedge clock)
    begin
      if (!rst_b)
        prev_sign[ch] <= 1'b0;
      else if (pop)
        prev_sign[ch] <= in_sample[ch][23];
    end

    always_ff @(posedge clock)
    begin
      if (!rst_b)
        out_data[ch] <= '0;
      else if (s1_valid)
        out_data[ch] <= silent ? '0 : sat24(scaled);
    end
  end

  // handshake stages
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      s1_valid <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      s1_valid <= pop;
      if (s1_valid)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

  // sticky hazard flags; an event beats the clearing read
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      retune_seen <= 1'b0;
      rewrite_seen <= 1'b0;
    end
    else
    begin
      retune_seen <= tune_hazard || (retune_seen && !status_rd);
      rewrite_seen <= (|early_rewrite) || (rewrite_seen && !status_rd);
    end
  end

  assign out_left = out_data[0];
  assign out_right = out_data[1];

endmodule : alc_input_volume_deemphasis
`default_nettype wire

// File: rtl/alc_vol_defines.svh
// register offsets, field positions, reset values and counts for the volume path
`ifndef ALC_VOL_DEFINES_SVH
`define ALC_VOL_DEFINES_SVH

// register offsets
`define ADDR_CTRL 8'h00
`define ADDR_ZC_CFG 8'h01
`define ADDR_LIM_CFG 8'h02
`define ADDR_REC_CEIL 8'h03
`define ADDR_PLAY_CEIL 8'h04
`define ADDR_VOL_LEFT 8'h05
`define ADDR_VOL_RIGHT 8'h06
`define ADDR_APPLIED_LEFT 8'h07
`define ADDR_APPLIED_RIGHT 8'h08
`define ADDR_STATUS 8'h09

// control register fields
`define CTRL_REC_EN 0
`define CTRL_PLAY_EN 1
`define CTRL_PATH_SEL 2
`define CTRL_POWER 3
`define CTRL_LINK 4
`define CTRL_DEEMPH_LSB 5

// timing register fields
`define ZC_SEL_LSB 0
`define ZC_LIM_DIS 7
`define WAIT_SEL_LSB 2

// reset values
`define CTRL_RESET 8'h20
`define ZC_CFG_RESET 8'h00
`define LIM_CFG_RESET 8'h00
`define REC_CEIL_RESET 8'hE1
`define PLAY_CEIL_RESET 6'h28
`define IN_VOL_RESET 8'hE1

// volume code of 0 dB, of mute and of the +36dB top step
`define VOL_UNITY 9'h091
`define VOL_MUTE 8'h00
`define VOL_MAX 8'hF1

// shortest crossing timeout in sample periods
`define ZC_BASE_COUNT 11'h080

`define FIFO_DEPTH 16

// de-emphasis coefficients, Q2.14
`define DE441_B0 (18'sh1B7B)
`define DE441_B1 (-18'sh03D2)
`define DE441_A1 (-18'sh2857)
`define DE48_B0 (18'sh1AED)
`define DE48_B1 (-18'sh04DC)
`define DE48_A1 (-18'sh29EF)
`define DE32_B0 (18'sh1DDE)
`define DE32_B1 (18'sh009C)
`define DE32_A1 (-18'sh2186)

`endif

// File: rtl/alc_vol_pkg.sv
// types shared by the volume and de-emphasis path
package alc_vol_pkg;

  typedef logic signed [23:0] sample_t;

  typedef enum logic [1:0] {
    DEEMPH_44K1 = 2'h0,
    DEEMPH_OFF = 2'h1,
    DEEMPH_48K = 2'h2,
    DEEMPH_32K = 2'h3
  } deemph_mode_t;

  typedef enum logic [1:0] {
    VOL_ZERO,
    VOL_MANUAL,
    VOL_LEVEL_CTRL
  } vol_mode_t;

endpackage : alc_vol_pkg

// File: rtl/sample_fifo.sv
// sample buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  wire logic [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_valid = count != '0;
  assign out_data = store[rd_ptr];

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
      rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

endmodule : sample_fifo
`default_nettype wire

// File: rtl/deemph_filter.sv
// first-order de-emphasis shelving filter for one channel
`include "alc_vol_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module deemph_filter
  import alc_vol_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // control
  input wire logic step,
  input wire deemph_mode_t mode,
  // samples
  input wire sample_t x,
  output sample_t y
);
  sample_t x1;

  wire logic signed [17:0] b0 = mode == DEEMPH_48K ? `DE48_B0 : mode == DEEMPH_32K ? `DE32_B0 : `DE441_B0;
  wire logic signed [17:0] b1 = mode == DEEMPH_48K ? `DE48_B1 : mode == DEEMPH_32K ? `DE32_B1 : `DE441_B1;
  wire logic signed [17:0] a1 = mode == DEEMPH_48K ? `DE48_A1 : mode == DEEMPH_32K ? `DE32_A1 : `DE441_A1;
  wire logic signed [43:0] acc = 44'(b0) * 44'(x) + 44'(b1) * 44'(x1) - 44'(a1) * 44'(y);
  wire logic signed [29:0] shifted = acc[43:14];
  wire logic fits = shifted[29:23] == {7{shifted[23]}};
  wire sample_t filtered = fits ? shifted[23:0] : {shifted[29], {23{~shifted[29]}}};

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      x1 <= '0;
      y <= '0;
    end
    else if (step)
    begin
      x1 <= x;
      y <= mode == DEEMPH_OFF ? x : filtered;
    end
  end

endmodule : deemph_filter
`default_nettype wire

// File: testbench/alc_vol_monitor.sv
// port-level checker for the volume and de-emphasis path
`include "alc_vol_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module alc_vol_monitor
  import alc_vol_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // sample streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [23:0] out_left,
  input wire logic [23:0] out_right,
  input wire logic out_ready
);
  logic [7:0] ctrl;
  logic [7:0] zc_cfg;
  logic [3:0] quiet;
  logic [5:0] occ;
  wire ctrl_wr = reg_wr && reg_addr == `ADDR_CTRL;
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ctrl <= `CTRL_RESET;
      zc_cfg <= `ZC_CFG_RESET;
      quiet <= 4'h0;
      occ <= 6'h00;
    end
    else
    begin
      if (ctrl_wr)
        ctrl <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_ZC_CFG)
        zc_cfg <= reg_wdata;
      quiet <= ctrl_wr ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      occ <= occ + {5'h00, in_valid && in_ready} - {5'h00, out_valid && out_ready};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  rd_quiet_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside a read cycle");
  ceil_width_a: assert property (reg_rd && reg_addr == `ADDR_PLAY_CEIL |=> reg_rdata[7:6] == 2'b00)
    else $error("playback ceiling wider than six bits");
  ctrl_back_a: assert property (reg_rd && reg_addr == `ADDR_CTRL |=> reg_rdata[6:0] == ctrl[6:0])
    else $error("control readback differs");
  zc_back_a: assert property (reg_rd && reg_addr == `ADDR_ZC_CFG |=> reg_rdata == zc_cfg)
    else $error("timeout config readback differs");
  manual_flag_a: assert property (reg_rd && reg_addr == `ADDR_STATUS |=> reg_rdata[1] == (ctrl[2] && !ctrl[0]))
    else $error("manual mode flag wrong");
  wait_flag_a: assert property (reg_rd && reg_addr == `ADDR_STATUS |=> reg_rdata[5] == (zc_cfg[4:2] < {1'b0, zc_cfg[1:0]}))
    else $error("short wait flag wrong");
  zero_out_a: assert property ($rose(out_valid) && quiet > 4'h3 && ctrl[2:0] == 3'h0 |->
    out_left == 24'h00_0000 && out_right == 24'h00_0000)
    else $error("output not zero with level control off");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_left) && $stable(out_right))
    else $error("output changed while stalled");
  room_ready_a: assert property (occ < 6'h0E && $past(occ) < 6'h0E |-> in_ready)
    else $error("input refused with room left");
  cover property (out_valid && !out_ready);
  cover property (in_valid && !in_ready);
  cover property (reg_rd && reg_addr == `ADDR_STATUS);
endmodule : alc_vol_monitor
bind alc_input_volume_deemphasis alc_vol_monitor i_alc_vol_monitor (
  .clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .in_valid, .in_ready, .out_valid, .out_left, .out_right, .out_ready
);
`default_nettype wire

// File: testbench/alc_input_volume_deemphasis_bench.sv
// self-checking bench for the volume and de-emphasis path
`include "alc_vol_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module alc_input_volume_deemphasis_bench
  import alc_vol_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic in_valid = 1'b0;
  logic [23:0] in_left = 24'h00_0000;
  logic [23:0] in_right = 24'h00_0000;
  logic in_ready;
  logic out_valid;
  logic [23:0] out_left;
  logic [23:0] out_right;
  logic out_ready = 1'b1;
  logic [23:0] got_l;
  logic [23:0] got_r;
  logic [7:0] vols [4] = '{8'h91, 8'h85, 8'h9A, 8'h91};
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int k;
  localparam logic [23:0] pos = 24'h00_0100;
  localparam logic [23:0] neg = 24'hFF_FF00;
  localparam logic [23:0] step_val = 24'h10_0000;
  alc_input_volume_deemphasis i_alc_input_volume_deemphasis (
    .clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .in_valid, .in_left, .in_right, .in_ready, .out_valid, .out_left, .out_right, .out_ready
  );
  initial
    forever #2.5 clock = ~clock;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      $display("BAD timeout after %0d cycles", cycles);
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic peek(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
  endtask : peek
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    peek(a);
    chk(name, {16'h0000, exp}, {16'h0000, reg_rdata});
  endtask : rd
  // one sample pair in, one processed pair out
  task automatic xfer(input logic [23:0] l, input logic [23:0] r);
    @(posedge clock);
    in_valid <= 1'b1;
    in_left <= l;
    in_right <= r;
    do
      @(posedge clock);
    while (!in_ready);
    in_valid <= 1'b0;
    do
      @(posedge clock);
    while (!out_valid);
    got_l = out_left;
    got_r = out_right;
  endtask : xfer
  task automatic run(input int n);
    repeat (n) xfer(pos, pos);
  endtask : run
  initial
  begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rd(`ADDR_CTRL, 8'h20, "ctrl");
    rd(`ADDR_ZC_CFG, 8'h00, "zc_cfg");
    rd(`ADDR_REC_CEIL, 8'hE1, "rec_ceiling");
    rd(`ADDR_PLAY_CEIL, 8'h28, "play_ceiling");
    rd(`ADDR_VOL_LEFT, 8'hE1, "in_vol_left");
    rd(`ADDR_VOL_RIGHT, 8'hE1, "in_vol_right");
    rd(8'h0A, 8'h00, "unmapped");
    $display("reset values done");
    wr(`ADDR_CTRL, 8'h24);
    rd(`ADDR_STATUS, 8'h02, "manual_status");
    wr(`ADDR_VOL_LEFT, 8'h91);
    run(150);
    rd(`ADDR_APPLIED_LEFT, 8'hE1, "held_left");
    wr(`ADDR_CTRL, 8'h2C);
    // rewrite of the same value halfway must not restart the count
    for (int z = 0; z < 4; z++)
    begin
      wr(`ADDR_ZC_CFG, {3'h0, 3'(z), 2'(z)});
      wr(`ADDR_VOL_LEFT, vols[z]);
      run(64 << z);
      wr(`ADDR_VOL_LEFT, vols[z]);
      run((64 << z) - 1);
      rd(`ADDR_APPLIED_LEFT, z != 0 ? vols[z - 1] : 8'hE1, "before_timeout");
      run(1);
      rd(`ADDR_APPLIED_LEFT, vols[z], "after_timeout");
    end
    rd(`ADDR_APPLIED_RIGHT, 8'hE1, "right_untouched");
    wr(`ADDR_ZC_CFG, 8'h03);
    rd(`ADDR_STATUS, 8'h22, "wait_short");
    wr(`ADDR_ZC_CFG, 8'h0F);
    wr(`ADDR_CTRL, 8'h2D);
    wr(`ADDR_LIM_CFG, 8'h00);
    rd(`ADDR_STATUS, 8'h44, "retune_flag");
    rd(`ADDR_STATUS, 8'h04, "retune_cleared");
    wr(`ADDR_CTRL, 8'h2C);
    wr(`ADDR_VOL_LEFT, 8'h70);
    wr(`ADDR_VOL_RIGHT, 8'h91);
    xfer(pos, neg);
    rd(`ADDR_APPLIED_RIGHT, 8'h91, "right_at_crossing");
    rd(`ADDR_APPLIED_LEFT, 8'h91, "left_waits");
    wr(`ADDR_CTRL, 8'h3C);
    wr(`ADDR_VOL_LEFT, 8'h60);
    xfer(neg, pos);
    rd(`ADDR_APPLIED_RIGHT, 8'h60, "linked_right");
    rd(`ADDR_STATUS, 8'h82, "rewrite_flag");
    wr(`ADDR_VOL_LEFT, 8'h91);
    xfer(pos, neg);
    $display("volume update tests done");
    for (int m = 0; m < 4; m++)
    begin
      wr(`ADDR_CTRL, {1'b0, 2'(m), 5'h0C});
      xfer(24'h00_0000, 24'h00_0000);
      xfer(step_val, step_val);
      chk("deemph_pass", 24'(m == 1), 24'(got_l === step_val));
    end
    wr(`ADDR_CTRL, 8'h2C);
    wr(`ADDR_VOL_LEFT, 8'h00);
    xfer(neg, neg);
    xfer(step_val, step_val);
    chk("muted_left", 24'h00_0000, got_l);
    chk("unity_right", step_val, got_r);
    wr(`ADDR_VOL_LEFT, 8'h91);
    xfer(neg, neg);
    wr(`ADDR_CTRL, 8'h08);
    xfer(step_val, step_val);
    chk("zero_left", 24'h00_0000, got_l);
    chk("zero_right", 24'h00_0000, got_r);
    wr(`ADDR_CTRL, 8'h2C);
    $display("filter and output tests done");
    k = 0;
    out_ready <= 1'b0;
    in_valid <= 1'b1;
    in_left <= 24'h00_0000;
    in_right <= 24'h00_0000;
    repeat (40)
    begin
      @(posedge clock);
      if (in_ready)
        k++;
      in_left <= 24'(k);
      in_right <= 24'(k);
    end
    in_valid <= 1'b0;
    out_ready <= 1'b1;
    chk("full_refused", 24'h00_0000, 24'(in_ready));
    chk("depth_reached", 24'h00_0001, 24'(k >= 16));
    for (int j = 0; j < k; j++)
    begin
      do
        @(posedge clock);
      while (!out_valid);
      chk("drain_order", 24'(j), out_left);
    end
    $display("buffer test done");
    end_of_test();
  end
endmodule : alc_input_volume_deemphasis_bench
`default_nettype wire
